// ==== src/arfc_host.sv ====
// host controller that resets, writes, reads and replays the strobe-driven 512x9 fifo device
//
// Overview of operation
// - reads need empty flag high for 10 ns; earlier reads may be ignored.
// - host must reset the device after power-up before writing.
// - strobes high 45 ns before reset rises and 15 ns after.
// - flags are trusted only 80 ns after reset ends; the code raises dev_ready and the flag outputs 60 ns after reset_n rises.
// - read strobe high 45 ns before replay rises and 15 ns after.
// - flags trusted only after the replay cycle time.
// - replay only in single-device use, best below 512 writes per reset.
// - parallel devices share controls; flags may be read from any one.
`timescale 1ns/100ps
module arfc_host
	import arfc_pkg::*;
(
	input  wire logic                ref_clk,
	input  wire logic                rst_n,
	input  wire logic                wr_valid,
	output logic                     wr_ready,
	input  wire logic [DATA_W-1:0]   wr_data,
	input  wire logic                rd_req,
	output logic                     rd_valid,
	input  wire logic                rd_ready,
	output logic      [DATA_W-1:0]   rd_data,
	input  wire logic                replay_req,
	output logic                     replay_ack,
	output logic                     dev_ready,
	output logic                     dev_empty,
	output logic                     dev_full,
	output logic                     write_n,
	output logic                     read_n,
	output logic                     reset_n,
	output logic                     first_load_or_replay_n,
	output logic                     chain_in_n,
	output logic      [DATA_W-1:0]   din,
	input  wire logic [DATA_W-1:0]   qout,
	input  wire logic                empty_flag_n,
	input  wire logic                full_flag_n
);
	typedef struct packed {
		arfc_state_t             st;
		logic [3:0]              cnt;
		logic [3:0]              settle;
		logic                    ef_m;
		logic                    ef_s;
		logic                    ff_m;
		logic                    ff_s;
		logic [DATA_W-1:0]       q_m;
		logic [DATA_W-1:0]       q_s;
		logic                    wn;
		logic                    rn;
		logic                    rsn;
		logic                    rtn;
		logic [DATA_W-1:0]       dout;
		logic                    up;
		logic                    ack;
		logic                    pend_rt;
		logic                    cap_v;
		logic [DATA_W-1:0]       cap_d;
		logic                    wr_rdy;
		logic                    emp;
		logic                    ful;
	} arfc_host_t;

	arfc_host_t r_reg;
	arfc_host_t r_next;
	logic       buf_ready;

	always_comb
	begin
		r_next = r_reg;
		// pins come from another domain: two flops before use
		r_next.ef_m = empty_flag_n;
		r_next.ef_s = r_reg.ef_m;
		r_next.ff_m = full_flag_n;
		r_next.ff_s = r_reg.ff_m;
		r_next.q_m = qout;
		r_next.q_s = r_reg.q_m;
		r_next.ack = 1'b0;
		r_next.wr_rdy = 1'b0;
		if (replay_req)
			r_next.pend_rt = 1'b1;
		if (buf_ready)
			r_next.cap_v = 1'b0;
		if (r_reg.settle != CNT_W_ZERO)
			r_next.settle = r_reg.settle - 4'h1;
		if (r_reg.cnt != CNT_W_ZERO)
			r_next.cnt = r_reg.cnt - 4'h1;
		case (r_reg.st)
			ARFC_RESET_LOW:
			begin
				r_next.rsn = 1'b0;
				r_next.wn = 1'b1;
				r_next.rn = 1'b1;
				r_next.rtn = 1'b1;
				if (r_reg.cnt == CNT_W_ZERO)
				begin
					r_next.rsn = 1'b1;
					r_next.cnt = POST_RESET;
					r_next.st = ARFC_RESET_REC;
				end
			end
			ARFC_RESET_REC:
			begin
				// strobes held high and flags ignored until valid
				if (r_reg.cnt == CNT_W_ZERO)
				begin
					r_next.up = 1'b1;
					r_next.settle = SETTLE_LEN;
					r_next.st = ARFC_IDLE;
				end
			end
			ARFC_IDLE:
			begin
				if (r_reg.settle == CNT_W_ZERO && r_reg.pend_rt)
				begin
					r_next.pend_rt = replay_req; // a request in the serving cycle is kept
					r_next.cnt = RT_PRE;
					r_next.st = ARFC_RT_PRE;
				end
				// flag seen high after its settle delay, so reads avoid the protect window
				else if (r_reg.settle == CNT_W_ZERO && rd_req && r_reg.ef_s && !r_reg.cap_v)
				begin
					r_next.rn = 1'b0;
					r_next.cnt = PULSE_LEN;
					r_next.st = ARFC_RD_LOW;
				end
				else if (r_reg.settle == CNT_W_ZERO && wr_valid && r_reg.ff_s)
				begin
					r_next.dout = wr_data;
					r_next.wn = 1'b0;
					r_next.wr_rdy = 1'b1;
					r_next.cnt = PULSE_LEN;
					r_next.st = ARFC_WR_LOW;
				end
			end
			ARFC_WR_LOW:
			begin
				if (r_reg.cnt == CNT_W_ZERO)
				begin
					r_next.wn = 1'b1;
					r_next.cnt = RECOVER_LEN;
					r_next.settle = SETTLE_LEN;
					r_next.st = ARFC_RECOVER;
				end
			end
			ARFC_RD_LOW:
			begin
				if (r_reg.cnt == CNT_W_ZERO)
				begin
					// word sampled while strobe still low, before outputs float
					r_next.cap_v = 1'b1;
					r_next.cap_d = r_reg.q_s;
					r_next.rn = 1'b1;
					r_next.cnt = RECOVER_LEN;
					r_next.settle = SETTLE_LEN;
					r_next.st = ARFC_RECOVER;
				end
			end
			ARFC_RECOVER:
			begin
				if (r_reg.cnt == CNT_W_ZERO)
					r_next.st = ARFC_IDLE;
			end
			ARFC_RT_PRE:
			begin
				// read strobe already high this long before the replay pulse
				if (r_reg.cnt == CNT_W_ZERO)
				begin
					r_next.rtn = 1'b0;
					r_next.cnt = RT_LOW;
					r_next.st = ARFC_RT_LOW;
				end
			end
			ARFC_RT_LOW:
			begin
				if (r_reg.cnt == CNT_W_ZERO)
				begin
					r_next.rtn = 1'b1;
					r_next.cnt = RT_POST;
					r_next.st = ARFC_RT_POST;
				end
			end
			ARFC_RT_POST:
			begin
				if (r_reg.cnt == CNT_W_ZERO)
				begin
					r_next.ack = 1'b1;
					r_next.settle = SETTLE_LEN;
					r_next.st = ARFC_IDLE;
				end
			end
			default:
			begin
				r_next.st = ARFC_RESET_LOW;
				r_next.cnt = PRE_RESET;
			end
		endcase
		// flags registered from the synchronised copies so the ports come from flops
		r_next.emp = r_next.up & ~r_next.ef_s;
		r_next.ful = r_next.up & ~r_next.ff_s;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			r_reg <= '0;
			r_reg.st <= ARFC_RESET_LOW;
			r_reg.cnt <= PRE_RESET;
			r_reg.wn <= 1'b1;
			r_reg.rn <= 1'b1;
			r_reg.rtn <= 1'b1;
		end
		else
			r_reg <= r_next;
	end

	// word buffered so a stalled consumer loses nothing; reads wait while cap_v holds a word the full buffer has not taken
	arfc_skid u_skid (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.in_valid  (r_reg.cap_v),
		.in_ready  (buf_ready),
		.in_data   (r_reg.cap_d),
		.out_valid (rd_valid),
		.out_ready (rd_ready),
		.out_data  (rd_data)
	);

	assign wr_ready = r_reg.wr_rdy;
	assign replay_ack = r_reg.ack;
	assign dev_ready = r_reg.up;
	// flags of one device stand for all devices in a parallel group
	assign dev_empty = r_reg.emp;
	assign dev_full = r_reg.ful;
	assign write_n = r_reg.wn;
	assign read_n = r_reg.rn;
	assign reset_n = r_reg.rsn;
	assign first_load_or_replay_n = r_reg.rtn;
	assign chain_in_n = 1'b0;
	assign din = r_reg.dout;
endmodule

// ==== src/arfc_pkg.sv ====
// package: constants for the host-side controller of the 512x9 strobe-driven fifo device
package arfc_pkg;
	localparam int          DATA_W      = 9;
	localparam int          DEPTH       = 512;
	localparam int          CLK_NS      = 20;
	// documented times in ns
	localparam int          RESET_CYCLE_NS      = 80;
	localparam int          RESET_SETUP_NS      = 45;
	localparam int          RESET_RECOVERY_NS   = 15;
	localparam int          WRITE_NONEMPTY_NS   = 60;
	localparam int          READ_PROTECT_NS     = 35;
	localparam int          NONEMPTY_READ_NS    = 10;
	localparam int          REPLAY_SETUP_NS     = 45;
	localparam int          REPLAY_RECOVERY_NS  = 15;
	localparam int          REPLAY_CYCLE_NS     = 80;
	localparam int          PULSE_NS            = 65;
	localparam int          STROBE_RECOVERY_NS  = 15;
	// least times round up to whole cycles, at least one
	localparam int          RESET_CYC   = (RESET_CYCLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int          RSS_CYC     = (RESET_SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int          RSR_CYC     = (RESET_RECOVERY_NS + CLK_NS - 1) / CLK_NS;
	localparam int          EFR_CYC     = (NONEMPTY_READ_NS + CLK_NS - 1) / CLK_NS;
	localparam int          RTS_CYC     = (REPLAY_SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int          RTR_CYC     = (REPLAY_RECOVERY_NS + CLK_NS - 1) / CLK_NS;
	localparam int          RTC_CYC     = (REPLAY_CYCLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int          PULSE_CYC   = (PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int          REC_CYC     = (STROBE_RECOVERY_NS + CLK_NS - 1) / CLK_NS;
	localparam int          FLAG_CYC    = (WRITE_NONEMPTY_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0]  CNT_W_ZERO  = 4'h0;
	localparam logic [3:0]  PRE_RESET   = 4'(RSS_CYC > RESET_CYC ? RSS_CYC : RESET_CYC);
	localparam logic [3:0]  POST_RESET  = 4'(RSR_CYC + 1);
	localparam logic [3:0]  PULSE_LEN   = 4'(PULSE_CYC);
	localparam logic [3:0]  RECOVER_LEN = 4'(REC_CYC + EFR_CYC);
	localparam logic [3:0]  RT_PRE      = 4'(RTS_CYC);
	localparam logic [3:0]  RT_LOW      = 4'(PULSE_CYC);
	localparam logic [3:0]  RT_POST     = 4'(RTR_CYC + RTC_CYC);
	// flag delay plus the two synchroniser flops, so no decision sees a stale flag
	localparam logic [3:0]  SETTLE_LEN  = 4'(FLAG_CYC + 2);
	typedef enum logic [3:0] {
		ARFC_RESET_LOW, ARFC_RESET_REC, ARFC_IDLE, ARFC_WR_LOW, ARFC_RD_LOW,
		ARFC_RECOVER, ARFC_RT_PRE, ARFC_RT_LOW, ARFC_RT_POST
	} arfc_state_t;
endpackage

// ==== src/arfc_skid.sv ====
// two-entry valid/ready buffer carrying read words to the user
`timescale 1ns/100ps
module arfc_skid
	import arfc_pkg::*;
(
	input  wire logic                ref_clk,
	input  wire logic                rst_n,
	input  wire logic                in_valid,
	output logic                     in_ready,
	input  wire logic [DATA_W-1:0]   in_data,
	output logic                     out_valid,
	input  wire logic                out_ready,
	output logic      [DATA_W-1:0]   out_data
);
	typedef struct packed {
		logic [1:0]              cnt;
		logic [DATA_W-1:0]       d0;
		logic [DATA_W-1:0]       d1;
		logic                    vld;
	} arfc_skid_t;
	arfc_skid_t s_reg;
	arfc_skid_t s_next;
	logic       push;
	logic       pop;

	always_comb
	begin
		s_next = s_reg;
		push = in_valid && (s_reg.cnt != 2'h2);
		pop = (s_reg.cnt != 2'h0) && out_ready;
		if (pop)
		begin
			s_next.d0 = s_reg.d1;
		end
		if (push)
		begin
			if (s_reg.cnt == 2'h0 || (s_reg.cnt == 2'h1 && pop))
				s_next.d0 = in_data;
			else
				s_next.d1 = in_data;
		end
		s_next.cnt = s_reg.cnt + {1'b0, push} - {1'b0, pop};
		s_next.vld = (s_next.cnt != 2'h0);
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	// ready comes from state, not from out_ready, so no combinational path crosses the buffer
	assign in_ready = (s_reg.cnt != 2'h2);
	assign out_valid = s_reg.vld;
	assign out_data = s_reg.d0;
endmodule

// ==== tb/arfc_dev_model.sv ====
// behavioural model of the 512x9 strobe-driven fifo device
`timescale 1ns/100ps
module arfc_dev_model
	import arfc_pkg::*;
(
	input  wire logic              write_n,
	input  wire logic              read_n,
	input  wire logic              reset_n,
	input  wire logic              first_load_or_replay_n,
	input  wire logic              chain_in_n,
	input  wire logic [DATA_W-1:0] din,
	output logic      [DATA_W-1:0] qout,
	output logic                   empty_flag_n,
	output logic                   full_flag_n
);
	logic [DATA_W-1:0] mem [DEPTH];
	int                wp = 0, rp = 0, cnt = 0;
	logic              rd_on = 0, single = 0;
	initial qout = 9'h155;
	always @(negedge reset_n)
	begin
		wp = 0;
		rp = 0;
		cnt = 0;
		rd_on = 0;
	end
	always @(posedge reset_n) single = !chain_in_n;
	// independent write and read processes let both sides overlap
	always @(posedge write_n)
		if (reset_n && single && cnt < DEPTH)
		begin
			mem[wp] = din;
			wp = (wp + 1) % DEPTH;
			cnt++;
		end
	always @(negedge read_n)
		if (empty_flag_n === 1'b1 && single)
		begin
			rd_on = 1;
			qout <= #20 mem[rp];
			// the flag follows the start of the read, not its end
			rp = (rp + 1) % DEPTH;
			cnt--;
		end
	always @(posedge read_n)
		if (rd_on)
		begin
			rd_on = 0;
			qout <= #10 ~qout;
		end
	// rewind ignores wrap, as expected use is under 512 writes per reset
	always @(negedge first_load_or_replay_n)
		if (reset_n && single)
		begin
			rp = 0;
			cnt = wp;
		end
	assign #40 empty_flag_n = (cnt != 0);
	assign #40 full_flag_n = (cnt < DEPTH);
endmodule

// ==== tb/arfc_host_asserts.sv ====
// checker: port timing of the fifo host controller
`timescale 1ns/100ps
module arfc_host_asserts
	import arfc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic wr_ready,
	input wire logic replay_ack,
	input wire logic dev_ready,
	input wire logic dev_empty,
	input wire logic dev_full,
	input wire logic write_n,
	input wire logic read_n,
	input wire logic reset_n,
	input wire logic first_load_or_replay_n,
	input wire logic chain_in_n
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	AST_WR_ACK: assert property ($fell(write_n) |-> wr_ready)
		else $error("write strobe without acknowledge");
	AST_WR_PULSE: assert property ($fell(write_n) |=> !write_n[*4] ##1 write_n)
		else $error("write strobe length wrong");
	AST_WR_FULL: assert property ($fell(write_n) |-> !$past(dev_full))
		else $error("write issued while full");
	AST_RD_EMPTY: assert property ($fell(read_n) |-> !$past(dev_empty))
		else $error("read issued while empty");
	AST_RD_PULSE: assert property ($fell(read_n) |=> !read_n[*4] ##1 read_n)
		else $error("read strobe length wrong");
	AST_RST_STROBE: assert property ($rose(reset_n) |-> $past(write_n, 3) && $past(read_n, 3)
		##1 write_n && read_n)
		else $error("strobes not idle around reset release");
	AST_RT_PULSE: assert property ($fell(first_load_or_replay_n)
		|=> !first_load_or_replay_n[*4] ##1 first_load_or_replay_n)
		else $error("replay pulse length wrong");
	AST_RT_SETUP: assert property ($rose(first_load_or_replay_n)
		|-> read_n && $past(read_n, 3) ##1 read_n)
		else $error("read strobe active near replay");
	AST_RT_ACK: assert property ($rose(first_load_or_replay_n) |-> ##6 replay_ack)
		else $error("replay ack timing wrong");
	AST_CHAIN: assert property (chain_in_n == 1'b0)
		else $error("chain input not grounded");
	AST_NO_EARLY_WR: assert property (!dev_ready |-> write_n && !dev_empty && !dev_full)
		else $error("activity before device ready");
endmodule

// ==== tb/test_async_ring_fifo_512x9.sv ====
// testbench: host controller against the fifo device model
`timescale 1ns/100ps
module test_async_ring_fifo_512x9;
	import arfc_pkg::*;
	logic              ref_clk = 0, rst_n = 0, wr_valid = 0, rd_req = 0, rd_ready = 0;
	logic              replay_req = 0, wr_ready, rd_valid, replay_ack, dev_ready;
	logic              dev_empty, dev_full, write_n, read_n, reset_n, replay_n, chain_in_n;
	logic              empty_flag_n, full_flag_n;
	logic [DATA_W-1:0] wr_data = '0, rd_data, din, qout;
	logic [DATA_W-1:0] expq [$], hist [$];
	logic [31:0]       seed = 32'h816daecb, rs = 32'h816daecb;
	int                n_fail = 0, n_compared = 0, i, k;
	always #10 ref_clk = ~ref_clk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	arfc_host i_arfc_host (.ref_clk(ref_clk), .rst_n(rst_n), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .wr_data(wr_data), .rd_req(rd_req), .rd_valid(rd_valid),
		.rd_ready(rd_ready), .rd_data(rd_data), .replay_req(replay_req), .replay_ack(replay_ack),
		.dev_ready(dev_ready), .dev_empty(dev_empty), .dev_full(dev_full), .write_n(write_n),
		.read_n(read_n), .reset_n(reset_n), .first_load_or_replay_n(replay_n),
		.chain_in_n(chain_in_n), .din(din), .qout(qout), .empty_flag_n(empty_flag_n),
		.full_flag_n(full_flag_n));
	arfc_dev_model i_arfc_dev_model (.write_n(write_n), .read_n(read_n), .reset_n(reset_n),
		.first_load_or_replay_n(replay_n), .chain_in_n(chain_in_n), .din(din), .qout(qout),
		.empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n));
	task automatic chk(input string what, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
		n_compared++;
		if (g !== e)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic put(input logic [DATA_W-1:0] w);
		int t;
		@(negedge ref_clk);
		wr_valid = 1;
		wr_data = w;
		t = 0;
		while (wr_ready !== 1'b1 && t < 60)
		begin
			@(negedge ref_clk);
			t++;
		end
		wr_valid = 0;
		chk("write taken", 1, 9'(wr_ready));
		expq.push_back(w);
		hist.push_back(w);
	endtask
	task automatic drain();
		int t;
		t = 0;
		rd_req = 1;
		while (expq.size() != 0 && t < 20000)
		begin
			@(negedge ref_clk);
			t++;
		end
		repeat (30) @(negedge ref_clk);
		rd_req = 0;
		chk("words left", 0, 9'(expq.size()));
		chk("empty flag", 1, 9'(dev_empty));
		chk("full flag", 0, 9'(dev_full));
	endtask
	// random stalls on the user side exercise the two-entry buffer
	always @(negedge ref_clk)
	begin
		rs = lfsr(rs);
		rd_ready <= rs[0] | rs[1];
	end
	always @(posedge ref_clk)
		if (rd_valid === 1'b1 && rd_ready === 1'b1)
		begin
			if (expq.size() == 0)
			begin
				n_fail++;
				$display("CHECK FAILED extra word expected none seen %h", rd_data);
			end
			else chk("read word", expq.pop_front(), rd_data);
		end
	initial
	begin
		#(60000 * CLK_NS);
		n_fail++;
		results();
	end
	initial
	begin
		repeat (3) @(negedge ref_clk);
		rst_n = 1;
		for (k = 0; k < 50 && dev_ready !== 1'b1; k++) @(negedge ref_clk);
		chk("device ready", 1, 9'(dev_ready));
		repeat (10) @(negedge ref_clk);
		chk("empty after reset", 1, 9'(dev_empty));
		for (i = 0; i < 8; i++)
		begin
			seed = lfsr(seed);
			put(seed[8:0]);
		end
		drain();
		$display("test order done");
		replay_req = 1;
		@(negedge ref_clk);
		replay_req = 0;
		for (k = 0; k < 50 && replay_ack !== 1'b1; k++) @(negedge ref_clk);
		chk("replay ack", 1, 9'(replay_ack));
		foreach (hist[j]) expq.push_back(hist[j]);
		drain();
		$display("test replay done");
		for (i = 0; i < DEPTH; i++)
		begin
			seed = lfsr(seed);
			put(i == 0 ? 9'h000 : (i == DEPTH - 1 ? 9'h1ff : seed[8:0]));
		end
		repeat (10) @(negedge ref_clk);
		chk("full after fill", 1, 9'(dev_full));
		wr_valid = 1;
		wr_data = 9'h0aa;
		k = 0;
		repeat (40) @(negedge ref_clk) k += int'(wr_ready === 1'b1);
		wr_valid = 0;
		chk("write while full", 0, 9'(k));
		drain();
		$display("test fill done");
		results();
	end
endmodule
bind arfc_host arfc_host_asserts i_arfc_host_asserts (.ref_clk(ref_clk), .rst_n(rst_n),
	.wr_ready(wr_ready), .replay_ack(replay_ack), .dev_ready(dev_ready), .dev_empty(dev_empty),
	.dev_full(dev_full), .write_n(write_n), .read_n(read_n), .reset_n(reset_n),
	.first_load_or_replay_n(first_load_or_replay_n), .chain_in_n(chain_in_n));
